// [design/scb_config_bank.sv]
`default_nettype none
module scb_config_bank
  import scb_pkg::*;
(
  input wire logic clk, // 100 MHz internal clock
  input wire logic rst, // Power-on reset
  input wire logic config_mode, // Chip is in configuration mode
  input wire logic sleep_enabled, // Sleep mode allowed by system register
  input wire logic serial_sel_n, // Serial chip select, pin
  input wire logic serial_clk, // Serial clock, pin
  input wire logic serial_in, // Serial data in, pin
  output logic serial_out, // Serial data out
  output logic serial_out_oe_n, // Low while driving serial_out
  output logic bus_wake_en, // Bus wake detection active
  output logic [1:0] local_wake_one_edge_sel, // Edge select input one
  output logic [1:0] local_wake_two_edge_sel, // Edge select input two
  output logic power_on_wake_only, // No wake source while sleep allowed
  output logic supply_undervolt_detect_off, // Undervoltage detect disabled
  output logic transceiver_off, // Transceiver disabled
  output logic fast_slope_temp, // Fast slope until next power-on
  output logic fast_slope_perm, // Fast slope permanent
  output logic transmit_timeout_off, // Transmit timeout disabled
  output logic timer_software_dev_mode, // Software development mode
  output logic timer_autonomous_mode, // Autonomous mode
  output logic [7:0] timer_period_ms, // Supervision period in ms
  output logic timer_window, // Window mode
  output logic timer_timeout, // Timeout mode
  output logic [7:0] cyclic_bias_settle_us, // Bias settle time in us
  output logic [7:0] cyclic_sample_period_ms, // Sample period in ms
  output logic output_polarity_invert, // Output inverted
  output logic [2:0] output_function_sel // Output function code
);
  import scb_pkg::*;

  logic [7:0] wake_source_config;
  logic [7:0] regulator_config;
  logic [7:0] bus_transceiver_config;
  logic [7:0] supervision_timer_config;
  logic [7:0] multipurpose_output_config;

  // Pin synchronisers
  // Clock flops reset to the idle low level so reset itself makes no false edge
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic sel_n_d;
  logic sclk_d;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta <= 3'h5;
      pin_sync <= 3'h5;
      sel_n_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      pin_meta <= {serial_sel_n, serial_clk, serial_in};
      pin_sync <= pin_meta;
      sel_n_d <= pin_sync[2];
      sclk_d <= pin_sync[1];
    end
  end

  wire sel_n_s = pin_sync[2];
  wire sclk_s = pin_sync[1];
  wire sdi_s = pin_sync[0];
  wire frame_start = sel_n_d && !sel_n_s;
  wire frame_end = !sel_n_d && sel_n_s;
  wire sample_edge = !sel_n_s && sclk_d && !sclk_s;
  wire shift_edge = !sel_n_s && !sclk_d && sclk_s;

  function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [7:0] w, input logic [7:0] r,
                                          input logic [7:0] x, input logic [7:0] t, input logic [7:0] o);
    unique case (a)
      ADDR_WAKE: read_reg = w;
      ADDR_REG: read_reg = r;
      ADDR_XCVR: read_reg = x;
      ADDR_TIMER: read_reg = t;
      ADDR_OUT: read_reg = o;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // Frame state
  logic [4:0] bit_cnt;
  logic [7:0] shreg;
  logic [6:0] cur_addr;
  logic read_only;
  logic [7:0] pend1;
  logic [7:0] pend2;
  logic [7:0] tx_shift;

  wire [7:0] next_shreg = {shreg[6:0], sdi_s};
  wire byte_done = sample_edge && (bit_cnt[2:0] == 3'h7);
  wire [7:0] cur_read = read_reg(cur_addr, wake_source_config, regulator_config,
                                 bus_transceiver_config, supervision_timer_config, multipurpose_output_config);
  wire [6:0] addr_p1 = cur_addr + 7'h01;
  wire [7:0] next_read = read_reg(addr_p1, wake_source_config, regulator_config,
                                  bus_transceiver_config, supervision_timer_config, multipurpose_output_config);
  // Write lands only at frame end, so a cut or overlong frame never changes a register
  wire commit = frame_end && config_mode && !read_only &&
                (bit_cnt == FRAME_BITS_W || bit_cnt == FRAME_BITS_L);
  wire second_ok = (bit_cnt == FRAME_BITS_L);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 5'h00;
      shreg <= 8'h00;
      cur_addr <= 7'h00;
      read_only <= 1'b1;
      pend1 <= 8'h00;
      pend2 <= 8'h00;
      tx_shift <= 8'h00;
    end else if (frame_start) begin
      bit_cnt <= 5'h00;
      read_only <= 1'b1;
      tx_shift <= 8'h00;
    end else if (sample_edge) begin
      bit_cnt <= (bit_cnt == 5'h1f) ? bit_cnt : bit_cnt + 5'h01;
      shreg <= next_shreg;
      if (byte_done && bit_cnt[4:3] == 2'h0) begin
        cur_addr <= next_shreg[7:1];
        read_only <= next_shreg[0];
      end else if (byte_done && bit_cnt[4:3] == 2'h1) begin
        pend1 <= next_shreg;
      end else if (byte_done && bit_cnt[4:3] == 2'h2) begin
        pend2 <= next_shreg;
      end
    end else if (shift_edge) begin
      // Prior content of the addressed register goes out during the data byte
      if (bit_cnt == 5'd8) begin
        tx_shift <= {cur_read[6:0], 1'b0};
      end else if (bit_cnt == 5'd16) begin
        tx_shift <= {next_read[6:0], 1'b0};
      end else begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  wire [7:0] tx_bit_src = (bit_cnt == 5'd8) ? cur_read : (bit_cnt == 5'd16) ? next_read : tx_shift;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else begin
      serial_out_oe_n <= !(config_mode && !sel_n_s);
      if (shift_edge) begin
        serial_out <= tx_bit_src[7];
      end else if (sel_n_s) begin
        serial_out <= 1'b0;
      end
    end
  end

  function automatic logic [7:0] upd(input logic [7:0] old, input logic [6:0] a, input logic [6:0] me,
                                     input logic [7:0] mask, input logic hit2, input logic [7:0] d1,
                                     input logic [7:0] d2);
    if (a == me) begin
      upd = d1 & mask;
    end else if (hit2 && (a + 7'h01) == me) begin
      upd = d2 & mask;
    end else begin
      upd = old;
    end
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_source_config <= RESET_VAL;
      regulator_config <= RESET_VAL;
      bus_transceiver_config <= RESET_VAL;
      supervision_timer_config <= RESET_VAL;
      multipurpose_output_config <= RESET_VAL;
    end else if (commit) begin
      wake_source_config <= upd(wake_source_config, cur_addr, ADDR_WAKE, MASK_WAKE, second_ok, pend1, pend2);
      regulator_config <= upd(regulator_config, cur_addr, ADDR_REG, MASK_REG, second_ok, pend1, pend2);
      bus_transceiver_config <= upd(bus_transceiver_config, cur_addr, ADDR_XCVR, MASK_XCVR, second_ok, pend1, pend2);
      supervision_timer_config <= upd(supervision_timer_config, cur_addr, ADDR_TIMER, MASK_TIMER, second_ok,
                                      pend1, pend2);
      multipurpose_output_config <= upd(multipurpose_output_config, cur_addr, ADDR_OUT, MASK_OUT, second_ok,
                                        pend1, pend2);
    end
  end

  // Decoded controls
  wire next_bus_wake = wake_source_config[BUS_WAKE_BIT] && !bus_transceiver_config[XCVR_OFF_BIT];
  wire [1:0] hs = bus_transceiver_config[2:1];
  wire [1:0] tp = supervision_timer_config[5:4];
  wire [7:0] next_period = (tp == 2'h0) ? PERIOD_MS0 : (tp == 2'h1) ? PERIOD_MS1 :
                           (tp == 2'h2) ? PERIOD_MS2 : PERIOD_MS3;
  wire no_wake = !next_bus_wake && (wake_source_config[3:0] == 4'h0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_wake_en <= 1'b0;
      local_wake_one_edge_sel <= SCB_EDGE_OFF;
      local_wake_two_edge_sel <= SCB_EDGE_OFF;
      power_on_wake_only <= 1'b0;
      supply_undervolt_detect_off <= 1'b0;
      transceiver_off <= 1'b0;
      fast_slope_temp <= 1'b0;
      fast_slope_perm <= 1'b0;
      transmit_timeout_off <= 1'b0;
      timer_software_dev_mode <= 1'b0;
      timer_autonomous_mode <= 1'b0;
      timer_period_ms <= PERIOD_MS0;
      timer_window <= 1'b0;
      timer_timeout <= 1'b0;
      cyclic_bias_settle_us <= SETTLE_US0;
      cyclic_sample_period_ms <= SAMPLE_MS0;
      output_polarity_invert <= 1'b0;
      output_function_sel <= SCB_OUT_OFF;
    end else begin
      bus_wake_en <= next_bus_wake;
      local_wake_one_edge_sel <= wake_source_config[1:0];
      local_wake_two_edge_sel <= wake_source_config[3:2];
      power_on_wake_only <= sleep_enabled && no_wake;
      supply_undervolt_detect_off <= regulator_config[UV_OFF_BIT];
      transceiver_off <= bus_transceiver_config[XCVR_OFF_BIT];
      fast_slope_temp <= (hs == 2'h1);
      fast_slope_perm <= (hs == 2'h2);
      transmit_timeout_off <= bus_transceiver_config[TXTO_OFF_BIT];
      timer_software_dev_mode <= supervision_timer_config[SDM_BIT];
      timer_autonomous_mode <= supervision_timer_config[AUTO_BIT];
      timer_period_ms <= next_period;
      timer_window <= (supervision_timer_config[1:0] == SCB_TMR_WINDOW);
      timer_timeout <= (supervision_timer_config[1:0] == SCB_TMR_TIMEOUT);
      cyclic_bias_settle_us <= multipurpose_output_config[SETTLE_BIT] ? SETTLE_US1 : SETTLE_US0;
      cyclic_sample_period_ms <= multipurpose_output_config[SAMPLE_BIT] ? SAMPLE_MS1 : SAMPLE_MS0;
      output_polarity_invert <= multipurpose_output_config[INV_BIT];
      output_function_sel <= multipurpose_output_config[2:0];
    end
  end

  property p_bus_wake;
    @(posedge clk) disable iff (rst)
      (wake_source_config[BUS_WAKE_BIT] && !bus_transceiver_config[XCVR_OFF_BIT]) |=> bus_wake_en;
  endproperty
  a_bus_wake: assert property (p_bus_wake) else $error("bus wake not enabled");

  property p_xcvr_blocks;
    @(posedge clk) disable iff (rst) bus_transceiver_config[XCVR_OFF_BIT] |=> !bus_wake_en;
  endproperty
  a_xcvr_blocks: assert property (p_xcvr_blocks) else $error("bus wake despite transceiver off");

  property p_edge_sel;
    @(posedge clk) disable iff (rst) 1'b1 |=> local_wake_two_edge_sel == $past(wake_source_config[3:2]);
  endproperty
  a_edge_sel: assert property (p_edge_sel) else $error("edge select mismatch");

  property p_fast_slope;
    @(posedge clk) disable iff (rst) (hs == 2'h3) |=> !fast_slope_temp && !fast_slope_perm;
  endproperty
  a_fast_slope: assert property (p_fast_slope) else $error("fast slope on for code 11");

  property p_timer_off;
    @(posedge clk) disable iff (rst) (supervision_timer_config[1:0] == 2'h3) |=> !timer_window && !timer_timeout;
  endproperty
  a_timer_off: assert property (p_timer_off) else $error("timer on for code 11");

  property p_period;
    @(posedge clk) disable iff (rst) (tp == 2'h3) |=> timer_period_ms == PERIOD_MS3;
  endproperty
  a_period: assert property (p_period) else $error("period not 128");

  property p_reserved;
    @(posedge clk) disable iff (rst)
      (supervision_timer_config & ~MASK_TIMER) == 8'h00 && (wake_source_config & ~MASK_WAKE) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_no_write_outside;
    @(posedge clk) disable iff (rst) !config_mode |=> $stable(multipurpose_output_config) && $stable(wake_source_config);
  endproperty
  a_no_write_outside: assert property (p_no_write_outside) else $error("write outside config mode");

  property p_settle;
    @(posedge clk) disable iff (rst) multipurpose_output_config[SETTLE_BIT] |=> cyclic_bias_settle_us == SETTLE_US1;
  endproperty
  a_settle: assert property (p_settle) else $error("settle not 134");
endmodule
`default_nettype wire

// [common/scb_pkg.sv]
`default_nettype none
package scb_pkg;
  localparam logic [6:0] ADDR_WAKE = 7'h11;
  localparam logic [6:0] ADDR_REG = 7'h12;
  localparam logic [6:0] ADDR_XCVR = 7'h13;
  localparam logic [6:0] ADDR_TIMER = 7'h14;
  localparam logic [6:0] ADDR_OUT = 7'h15;
  // Writable bit masks; reserved bits stay zero
  localparam logic [7:0] MASK_WAKE = 8'h1f;
  localparam logic [7:0] MASK_REG = 8'h01;
  localparam logic [7:0] MASK_XCVR = 8'h0f;
  localparam logic [7:0] MASK_TIMER = 8'hb7;
  localparam logic [7:0] MASK_OUT = 8'h3f;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam int BUS_WAKE_BIT = 4;
  localparam int XCVR_OFF_BIT = 3;
  localparam int UV_OFF_BIT = 0;
  localparam int TXTO_OFF_BIT = 0;
  localparam int SDM_BIT = 7;
  localparam int AUTO_BIT = 2;
  localparam int SETTLE_BIT = 5;
  localparam int SAMPLE_BIT = 4;
  localparam int INV_BIT = 3;
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_BITS_W = 5'd16;
  localparam logic [4:0] FRAME_BITS_L = 5'd24;
  typedef enum logic [1:0] {SCB_EDGE_OFF, SCB_EDGE_RISE, SCB_EDGE_FALL, SCB_EDGE_BOTH} scb_edge_t;
  typedef enum logic [1:0] {SCB_TMR_OFF, SCB_TMR_WINDOW, SCB_TMR_TIMEOUT} scb_tmr_t;
  typedef enum logic [2:0] {SCB_OUT_OFF, SCB_OUT_GPI, SCB_OUT_BIAS, SCB_OUT_LIMP,
                            SCB_OUT_NORM, SCB_OUT_NSP, SCB_OUT_NSPG, SCB_OUT_SLEEP} scb_out_t;
  // Supervision period in ms per code
  localparam logic [7:0] PERIOD_MS0 = 8'd16;
  localparam logic [7:0] PERIOD_MS1 = 8'd32;
  localparam logic [7:0] PERIOD_MS2 = 8'd64;
  localparam logic [7:0] PERIOD_MS3 = 8'd128;
  localparam logic [7:0] SAMPLE_MS0 = 8'd16;
  localparam logic [7:0] SAMPLE_MS1 = 8'd64;
  localparam logic [7:0] SETTLE_US0 = 8'd70;
  localparam logic [7:0] SETTLE_US1 = 8'd134;
endpackage
`default_nettype wire

// [sim/scb_host_model.sv]
`default_nettype none
module scb_host_model (
  input wire logic clk, // System clock
  output logic serial_sel_n, // Chip select to the device
  output logic serial_clk, // Serial clock to the device
  output logic serial_in, // Data to the device
  input wire logic serial_out // Data from the device
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_sel_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end
  // Sends n bits MSB first and collects what the device shifts back
  task automatic frame(input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = '0;
    @(posedge clk) serial_sel_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (5) @(posedge clk);
      serial_in <= tx[i];
      serial_clk <= 1'b1;
      repeat (5) @(posedge clk);
      serial_clk <= 1'b0;
      rx = {rx[22:0], serial_out};
    end
    repeat (5) @(posedge clk);
    serial_sel_n <= 1'b1;
    // Released data line must not keep showing the last bit
    serial_in <= ~serial_in;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [sim/scb_config_bank_tb.sv]
`default_nettype none
module scb_config_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic config_mode = 1'b0;
  logic sleep_enabled = 1'b0;
  logic serial_sel_n, serial_clk, serial_in, serial_out, serial_out_oe_n, bus_wake_en, power_on_wake_only;
  logic supply_undervolt_detect_off, transceiver_off, fast_slope_temp, fast_slope_perm, transmit_timeout_off;
  logic timer_software_dev_mode, timer_autonomous_mode, timer_window, timer_timeout, output_polarity_invert;
  logic [1:0] local_wake_one_edge_sel, local_wake_two_edge_sel;
  logic [7:0] timer_period_ms, cyclic_bias_settle_us, cyclic_sample_period_ms;
  logic [2:0] output_function_sel;
  logic [7:0] masks [5] = '{MASK_WAKE, MASK_REG, MASK_XCVR, MASK_TIMER, MASK_OUT};
  logic [7:0] periods [4] = '{PERIOD_MS0, PERIOD_MS1, PERIOD_MS2, PERIOD_MS3};
  int miscompares = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  scb_config_bank uut (.clk, .rst, .config_mode, .sleep_enabled, .serial_sel_n, .serial_clk, .serial_in,
    .serial_out, .serial_out_oe_n, .bus_wake_en, .local_wake_one_edge_sel, .local_wake_two_edge_sel,
    .power_on_wake_only, .supply_undervolt_detect_off, .transceiver_off, .fast_slope_temp, .fast_slope_perm,
    .transmit_timeout_off, .timer_software_dev_mode, .timer_autonomous_mode, .timer_period_ms, .timer_window,
    .timer_timeout, .cyclic_bias_settle_us, .cyclic_sample_period_ms, .output_polarity_invert,
    .output_function_sel);
  scb_host_model host (.clk, .serial_sel_n, .serial_clk, .serial_in, .serial_out);
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t value got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [23:0] r;
    host.frame(16, {8'h00, a, 1'b0, d}, r);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic [23:0] r;
    host.frame(16, {8'h00, a, 1'b1, 8'h00}, r);
    d = r[7:0];
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #800us;
    miscompares++;
    $display("[ERR] %0t run did not finish", $time);
    end_of_test();
  end
  initial begin
    logic [7:0] d;
    logic [23:0] r;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    config_mode <= 1'b1;
    repeat (4) @(posedge clk);
    chk8(timer_period_ms, PERIOD_MS0);
    chk8(cyclic_bias_settle_us, SETTLE_US0);
    chk8(cyclic_sample_period_ms, SAMPLE_MS0);
    chk1(serial_out_oe_n, 1'b1);
    for (int a = 0; a < 5; a++) begin
      rd(7'(ADDR_WAKE + a), d);
      chk8(d, RESET_VAL);
      wr(7'(ADDR_WAKE + a), 8'hff);
      rd(7'(ADDR_WAKE + a), d);
      chk8(d, masks[a]);
    end
    wr(ADDR_XCVR, 8'h00);
    sleep_enabled <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_WAKE, {4'h1, 2'(c), 2'(3 - c)});
      chk1(bus_wake_en, 1'b1);
      chk8({6'h0, local_wake_two_edge_sel}, 8'(c));
      chk8({6'h0, local_wake_one_edge_sel}, 8'(3 - c));
    end
    wr(ADDR_XCVR, 8'h08);
    chk1(transceiver_off, 1'b1);
    chk1(bus_wake_en, 1'b0);
    wr(ADDR_WAKE, 8'h10);
    chk1(power_on_wake_only, 1'b1);
    sleep_enabled <= 1'b0;
    repeat (2) @(posedge clk);
    chk1(power_on_wake_only, 1'b0);
    sleep_enabled <= 1'b1;
    wr(ADDR_WAKE, 8'h01);
    chk1(power_on_wake_only, 1'b0);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_XCVR, {5'h0, 2'(c), 1'(c)});
      chk1(fast_slope_temp, c == 1);
      chk1(fast_slope_perm, c == 2);
      chk1(transmit_timeout_off, 1'(c));
      chk1(transceiver_off, 1'b0);
    end
    wr(ADDR_REG, 8'h01);
    chk1(supply_undervolt_detect_off, 1'b1);
    wr(ADDR_REG, 8'h00);
    chk1(supply_undervolt_detect_off, 1'b0);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_TIMER, {1'(c), 1'b0, 2'(c), 1'b0, 1'(c >> 1), 2'(c)});
      chk8(timer_period_ms, periods[c]);
      chk1(timer_window, c == 1);
      chk1(timer_timeout, c == 2);
      chk1(timer_software_dev_mode, 1'(c));
      chk1(timer_autonomous_mode, 1'(c >> 1));
    end
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_OUT, {2'h0, 1'(c), 1'(c >> 1), 1'(c >> 2), 3'(c)});
      chk8({5'h0, output_function_sel}, 8'(c));
      chk8(cyclic_bias_settle_us, c[0] ? SETTLE_US1 : SETTLE_US0);
      chk8(cyclic_sample_period_ms, c[1] ? SAMPLE_MS1 : SAMPLE_MS0);
      chk1(output_polarity_invert, c[2]);
    end
    wr(ADDR_WAKE, 8'h0a);
    host.frame(24, {ADDR_WAKE, 1'b0, 8'h05, 8'h01}, r);
    chk8(r[15:8], 8'h0a);
    chk8(r[7:0], 8'h00);
    fork
      rd(ADDR_REG, d);
      begin
        repeat (20) @(posedge clk);
        chk1(serial_out_oe_n, 1'b0);
      end
    join
    chk8(d, 8'h01);
    host.frame(16, {8'h00, ADDR_WAKE, 1'b1, 8'h1f}, r);
    host.frame(12, {12'h0, ADDR_WAKE, 1'b0, 4'hf}, r);
    config_mode <= 1'b0;
    fork
      wr(ADDR_WAKE, 8'h1f);
      begin
        repeat (20) @(posedge clk);
        chk1(serial_out_oe_n, 1'b1);
      end
    join
    config_mode <= 1'b1;
    rd(ADDR_WAKE, d);
    chk8(d, 8'h05);
    wr(7'h20, 8'hff);
    rd(7'h20, d);
    chk8(d, 8'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(ADDR_WAKE, d);
    chk8(d, RESET_VAL);
    end_of_test();
  end
endmodule
`default_nettype wire
